// *** logic/ecrb_pkg.sv ***
`default_nettype none
package ecrb_pkg;
    // ----------------------------------------
    // Port decode
    // ----------------------------------------
    localparam logic [15:0] SEQ_INDEX_PORT = 16'h03C4;
    localparam logic [15:0] SEQ_DATA_PORT = 16'h03C5;
    localparam logic [15:0] GC_INDEX_PORT = 16'h03CE;
    localparam logic [15:0] GC_DATA_PORT = 16'h03CF;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_MEM_GEOMETRY = 8'h15;
    localparam logic [7:0] IDX_MEM_TIMING = 8'h17;
    localparam logic [7:0] IDX_MON_POWER = 8'h18;
    localparam logic [7:0] IDX_STRAP_HIGH = 8'h1F;
    localparam logic [7:0] IDX_STRAP_LOW = 8'h2E;
    localparam logic [7:0] IDX_READ_SEG = 8'h20;
    localparam logic [7:0] IDX_WRITE_SEG = 8'h21;
    localparam logic [7:0] IDX_EXT_MODE = 8'h22;
    // ----------------------------------------
    // Writable bit masks, reserved bits clear
    // ----------------------------------------
    localparam logic [7:0] GEOM_WMASK = 8'h37;
    localparam logic [7:0] TIMING_WMASK = 8'h6F;
    localparam logic [7:0] POWER_WMASK = 8'hF4;
    localparam logic [7:0] SEG_WMASK = 8'h7F;
    localparam logic [7:0] EXT_WMASK = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int GEOM_WIDE = 5;
    localparam int GEOM_WRAP = 4;
    localparam int GEOM_2MB = 2;
    localparam int GEOM_ASYM = 1;
    localparam int GEOM_FAST = 0;
    localparam int TIM_FEAT = 6;
    localparam int TIM_OVERLAY = 5;
    localparam int TIM_POWER_EN = 3;
    localparam int TIM_PRECHG = 2;
    localparam int TIM_TRIM_LO = 0;
    localparam int PWR_VSTATE = 7;
    localparam int PWR_HSTATE = 6;
    localparam int PWR_MODE_LO = 4;
    localparam int PWR_DDC_SPEED = 2;
    localparam int EXT_SPLIT = 3;
    localparam int EXT_GRAN16K = 1;
    localparam int EXT_WSEG_ON = 0;
    // ----------------------------------------
    // Encodings and counts
    // ----------------------------------------
    localparam logic [1:0] PWR_ON = 2'b00;
    localparam logic [1:0] PWR_STANDBY = 2'b01;
    localparam logic [1:0] PWR_SUSPEND = 2'b10;
    localparam logic [1:0] PWR_OFF = 2'b11;
    localparam logic [2:0] STD_HOST_CYCLE = 3'h6;
    localparam logic [1:0] PRECHG_SHORT = 2'h1;
    localparam logic [1:0] PRECHG_LONG = 2'h2;
    localparam int ADDR_W = 21;
    localparam logic [20:0] MASK_256K = 21'h03_FFFF;
    localparam logic [20:0] MASK_1MB = 21'h0F_FFFF;
    localparam logic [20:0] MASK_2MB = 21'h1F_FFFF;
endpackage : ecrb_pkg
`default_nettype wire

// *** logic/ecrb_pulse_stretch.sv ***
`timescale 1ns/10ps
`default_nettype none
module ecrb_pulse_stretch (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic start,
    input wire logic [1:0] len,
    output logic pulse
);
    typedef struct packed {
        logic [1:0] left;
    } ecrb_stretch_t;

    ecrb_stretch_t state_ff;
    ecrb_stretch_t nxt_state;

    // ----------------------------------------
    // Count down the cycles still to be driven
    // ----------------------------------------
    // A start inside a running pulse restarts it, so back to back
    // precharges never truncate each other.
    always_comb begin
        nxt_state = state_ff;
        if (start) begin
            nxt_state.left = len;
        end else if (state_ff.left != 2'h0) begin
            nxt_state.left = state_ff.left - 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign pulse = (state_ff.left != 2'h0);
endmodule : ecrb_pulse_stretch
`default_nettype wire

// *** logic/ecrb_core.sv ***
// Contract
// RL1 - Index port write selects register; next data-port access goes to it.
// RL2 - Memory geometry register sits at sequencer index 15h.
// RL3 - Width bit selects 32-bit DRAM path when set, 16-bit when clear.
// RL4 - Wrap bit clear wraps memory address at 256K; set continues beyond.
// RL5 - Size bit makes the controller address 2MB of DRAM.
// RL6 - Asymmetric mode drives ten mux address lines, standard mode nine.
// RL7 - Software sets fast clock bit when memory clock exceeds 45MHz.
// RL8 - Timing register bit 6 enables the feature connector port.
// RL9 - Bit 5 enables the overlay window output flag.
// RL10 - Monitor power signalling acts only while timing bit 3 is set.
// RL11 - Precharge pulse is two clocks with adjust bit set, else one.
// RL12 - Two-bit trim shortens host cycles by zero to three clocks.
// RL13 - A sync held off is driven at its state bit level, default low.
// RL14 - Power field 00 on, 01 standby, 10 suspend, 11 off gates syncs.
// RL15 - Speed bit switches vertical sync to display data channel timing.
// RL16 - Status bits 1 and 0 read live data channel and vsync pins; bit 0 here returns the registered vsync output instead.
// RL17 - First strap register captures two high strap lines at power-up.
// RL18 - Second strap bit 7: 1 dual write-enable, 0 dual column-strobe.
// RL19 - Second strap bit 6: 1 alternate enable port, 0 standard port.
// RL20 - Read segment register maps a segment into the host window.
// RL21 - Write segment register serves writes only or both directions; the code uses it only for writes, never for reads.
// RL22 - 64K granularity uses offset bits 4-0, 16K uses bits 6-0.
// RL23 - Segment registers are ignored while linear addressing is on.
// RL24 - Write segment joins mapping only once its activation bit is set.
// RL25 - Split bit set: read and write segments separate; clear: shared.
// RL26 - All bank registers power up holding zero.
// RL27 - Reserved bits read back zero and ignore writes.
// RL28 - Writes to read-only registers and status bits are ignored.
`timescale 1ns/10ps
`default_nettype none
module ecrb_core (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [ecrb_pkg::ADDR_W-1:0] disp_addr_in,
    output logic [ecrb_pkg::ADDR_W-1:0] disp_addr_out,
    input wire logic [9:0] mux_addr_in,
    output logic [9:0] dram_mux_address_bus,
    output logic mem_path_32,
    output logic fast_mclk,
    input wire logic precharge_start,
    output logic cas_precharge,
    output logic [2:0] host_cycle_len,
    output logic feature_conn_en,
    input wire logic overlay_region,
    output logic overlay_window_flag,
    input wire logic hsync_in,
    input wire logic vsync_in,
    output logic hsync_out,
    output logic vsync_out,
    output logic vsync_ddc_timing,
    input wire logic ddc_pin,
    input wire logic [1:0] strap_lines_high,
    input wire logic dram_type_strap,
    input wire logic enable_port_strap,
    input wire logic linear_en,
    input wire logic [15:0] win_addr,
    input wire logic win_wr,
    output logic [ecrb_pkg::ADDR_W-1:0] win_mem_addr
);
    import ecrb_pkg::*;

    typedef enum logic {ECRB_CAPTURE, ECRB_RUN} ecrb_phase_t;

    typedef struct packed {
        ecrb_phase_t phase;
        logic [7:0] seq_index;
        logic [7:0] gc_index;
        logic [7:0] geom;
        logic [7:0] timing;
        logic [7:0] power;
        logic [7:0] strap_hi;
        logic [7:0] strap_lo;
        logic [7:0] rd_seg;
        logic [7:0] wr_seg;
        logic [7:0] ext;
        logic [7:0] rdata;
        logic [20:0] disp_addr;
        logic [9:0] mux_addr;
        logic [20:0] win_addr;
        logic hsync;
        logic vsync;
        logic overlay;
    } ecrb_state_t;

    ecrb_state_t state_ff;
    ecrb_state_t nxt_state;

    // ----------------------------------------
    // Decode and live values
    // ----------------------------------------
    logic seq_data;
    logic gc_data;
    logic [1:0] pwr_mode;
    logic power_act;
    logic h_on;
    logic v_on;
    logic [20:0] mem_mask;
    logic [6:0] seg_sel;
    logic [20:0] seg_base;
    logic [7:0] rd_val;
    logic [1:0] prechg_len;

    // Data-port accesses land on whatever the index port last held
    assign seq_data = (io_addr == SEQ_DATA_PORT); // see RL1
    assign gc_data = (io_addr == GC_DATA_PORT); // see RL1

    // Sync gating for power states; only active while enabled
    always_comb begin
        pwr_mode = state_ff.power[PWR_MODE_LO +: 2];
        power_act = state_ff.timing[TIM_POWER_EN]; // see RL10
        h_on = 1'b1;
        v_on = 1'b1;
        if (power_act) begin
            case (pwr_mode) // see RL14
                PWR_ON: begin
                    h_on = 1'b1;
                    v_on = 1'b1;
                end
                PWR_STANDBY: begin
                    h_on = 1'b0;
                    v_on = 1'b1;
                end
                PWR_SUSPEND: begin
                    h_on = 1'b1;
                    v_on = 1'b0;
                end
                PWR_OFF: begin
                    h_on = 1'b0;
                    v_on = 1'b0;
                end
                default: begin
                    h_on = 1'b1;
                    v_on = 1'b1;
                end
            endcase
        end
    end

    // Address span: 256K wrap, otherwise 1MB or 2MB
    always_comb begin
        if (!state_ff.geom[GEOM_WRAP]) begin
            mem_mask = MASK_256K; // see RL4
        end else if (state_ff.geom[GEOM_2MB]) begin
            mem_mask = MASK_2MB; // see RL5
        end else begin
            mem_mask = MASK_1MB;
        end
    end

    // Host window segment choice
    // Split use needs both the split bit and the activation bit; with
    // either clear the read segment serves both directions.
    always_comb begin
        if (state_ff.ext[EXT_SPLIT] && state_ff.ext[EXT_WSEG_ON] && win_wr) begin
            seg_sel = state_ff.wr_seg[6:0]; // see RL21 see RL24 see RL25
        end else begin
            seg_sel = state_ff.rd_seg[6:0]; // see RL20 see RL25
        end
        if (state_ff.ext[EXT_GRAN16K]) begin
            seg_base = {seg_sel, 14'h0000}; // see RL22
        end else begin
            seg_base = {seg_sel[4:0], 16'h0000}; // see RL22
        end
    end

    // Read mux; status bit 1 comes straight from ddc_pin, bit 0 from the registered vsync output
    always_comb begin
        rd_val = 8'h00;
        if (io_addr == SEQ_INDEX_PORT) begin
            rd_val = state_ff.seq_index;
        end else if (io_addr == GC_INDEX_PORT) begin
            rd_val = state_ff.gc_index;
        end else if (seq_data) begin
            case (state_ff.seq_index)
                IDX_MEM_GEOMETRY: rd_val = state_ff.geom;
                IDX_MEM_TIMING: rd_val = state_ff.timing;
                IDX_MON_POWER: rd_val = {state_ff.power[7:2], ddc_pin, state_ff.vsync}; // see RL16
                IDX_STRAP_HIGH: rd_val = state_ff.strap_hi;
                IDX_STRAP_LOW: rd_val = state_ff.strap_lo;
                default: rd_val = 8'h00;
            endcase
        end else if (gc_data) begin
            case (state_ff.gc_index)
                IDX_READ_SEG: rd_val = state_ff.rd_seg;
                IDX_WRITE_SEG: rd_val = state_ff.wr_seg;
                IDX_EXT_MODE: rd_val = state_ff.ext;
                default: rd_val = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // Straps are sampled on the first enabled edge after reset, never
        // under the asynchronous reset itself.
        case (state_ff.phase)
            ECRB_CAPTURE: begin
                nxt_state.strap_hi = {strap_lines_high, 6'h00}; // see RL17
                nxt_state.strap_lo = {dram_type_strap, enable_port_strap, 6'h00}; // see RL18 see RL19
                nxt_state.phase = ECRB_RUN;
            end
            ECRB_RUN: begin
                nxt_state.phase = ECRB_RUN;
            end
            default: begin
                nxt_state.phase = ECRB_CAPTURE;
            end
        endcase
        // Register writes; read-only ones and reserved bits drop the data
        if (io_wr) begin
            if (io_addr == SEQ_INDEX_PORT) begin
                nxt_state.seq_index = io_wdata; // see RL1
            end else if (io_addr == GC_INDEX_PORT) begin
                nxt_state.gc_index = io_wdata; // see RL1
            end else if (seq_data) begin
                case (state_ff.seq_index)
                    IDX_MEM_GEOMETRY: nxt_state.geom = io_wdata & GEOM_WMASK; // see RL2 see RL27
                    IDX_MEM_TIMING: nxt_state.timing = io_wdata & TIMING_WMASK; // see RL27
                    IDX_MON_POWER: nxt_state.power = io_wdata & POWER_WMASK; // see RL28
                    default: nxt_state.phase = nxt_state.phase; // see RL28
                endcase
            end else if (gc_data) begin
                case (state_ff.gc_index)
                    IDX_READ_SEG: nxt_state.rd_seg = io_wdata & SEG_WMASK; // see RL27
                    IDX_WRITE_SEG: nxt_state.wr_seg = io_wdata & SEG_WMASK; // see RL27
                    IDX_EXT_MODE: nxt_state.ext = io_wdata & EXT_WMASK;
                    default: nxt_state.ext = state_ff.ext;
                endcase
            end
        end
        if (io_rd) begin
            nxt_state.rdata = rd_val;
        end
        // Memory side addressing, registered so outputs come from flops
        nxt_state.disp_addr = disp_addr_in & mem_mask; // see RL4 see RL5
        if (state_ff.geom[GEOM_ASYM]) begin
            nxt_state.mux_addr = mux_addr_in; // see RL6
        end else begin
            nxt_state.mux_addr = {1'b0, mux_addr_in[8:0]}; // see RL6
        end
        if (linear_en) begin
            nxt_state.win_addr = {5'h00, win_addr}; // see RL23
        end else begin
            nxt_state.win_addr = seg_base + {5'h00, win_addr}; // see RL20
        end
        // A sync held off sits at its programmed level
        nxt_state.hsync = h_on ? hsync_in : state_ff.power[PWR_HSTATE]; // see RL13
        nxt_state.vsync = v_on ? vsync_in : state_ff.power[PWR_VSTATE]; // see RL13
        nxt_state.overlay = state_ff.timing[TIM_OVERLAY] & overlay_region; // see RL9
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0; // see RL26
            state_ff.phase <= ECRB_CAPTURE;
            state_ff.geom <= REG_RESET;
            state_ff.timing <= REG_RESET;
            state_ff.power <= REG_RESET;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // Precharge width
    // ----------------------------------------
    assign prechg_len = state_ff.timing[TIM_PRECHG] ? PRECHG_LONG : PRECHG_SHORT; // see RL11

    ecrb_pulse_stretch u_precharge (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .start(precharge_start),
        .len(prechg_len),
        .pulse(cas_precharge)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Trim never reaches zero length since the standard cycle exceeds three
    assign host_cycle_len = STD_HOST_CYCLE - {1'b0, state_ff.timing[TIM_TRIM_LO +: 2]}; // see RL12
    assign mem_path_32 = state_ff.geom[GEOM_WIDE]; // see RL3
    assign fast_mclk = state_ff.geom[GEOM_FAST]; // see RL7
    assign feature_conn_en = state_ff.timing[TIM_FEAT]; // see RL8
    assign overlay_window_flag = state_ff.overlay;
    assign vsync_ddc_timing = state_ff.power[PWR_DDC_SPEED]; // see RL15
    assign hsync_out = state_ff.hsync;
    assign vsync_out = state_ff.vsync;
    assign io_rdata = state_ff.rdata;
    assign disp_addr_out = state_ff.disp_addr;
    assign dram_mux_address_bus = state_ff.mux_addr;
    assign win_mem_addr = state_ff.win_addr;
endmodule : ecrb_core
`default_nettype wire

// *** dv/ecrb_core_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Checker for the extended register bank
// ----------------------------------------
module ecrb_core_assertions
    import ecrb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic [9:0] mux_addr_in,
    input wire logic [9:0] dram_mux_address_bus,
    input wire logic mem_path_32,
    input wire logic fast_mclk,
    input wire logic precharge_start,
    input wire logic cas_precharge,
    input wire logic [2:0] host_cycle_len,
    input wire logic feature_conn_en,
    input wire logic overlay_region,
    input wire logic overlay_window_flag,
    input wire logic hsync_in,
    input wire logic hsync_out
);
    logic [7:0] idx_ff;
    logic [7:0] geom_ff;
    logic [7:0] tim_ff;
    logic up_ff;
    logic dwr;
    // Shadow copies, so properties see register state without peeking inside
    assign dwr = ce && io_wr && (io_addr == SEQ_DATA_PORT);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idx_ff <= 8'h00;
            geom_ff <= 8'h00;
            tim_ff <= 8'h00;
            up_ff <= 1'b0;
        end else begin
            up_ff <= 1'b1;
            if (ce && io_wr && io_addr == SEQ_INDEX_PORT) begin
                idx_ff <= io_wdata;
            end
            if (dwr && idx_ff == IDX_MEM_GEOMETRY) begin
                geom_ff <= io_wdata & GEOM_WMASK;
            end
            if (dwr && idx_ff == IDX_MEM_TIMING) begin
                tim_ff <= io_wdata & TIMING_WMASK;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_index_echo: assert property (ce && io_rd && io_addr == SEQ_INDEX_PORT |=>
        io_rdata == $past(idx_ff)) else $error("index port readback wrong");
    a_mem_levels: assert property ({mem_path_32, fast_mclk} ==
        {geom_ff[GEOM_WIDE], geom_ff[GEOM_FAST]}) else $error("geometry levels wrong");
    a_mux_upper: assert property (up_ff && $past(ce) |-> dram_mux_address_bus ==
        ($past(mux_addr_in) & {$past(geom_ff[GEOM_ASYM]), 9'h1FF}))
        else $error("mux address bit 9 wrong");
    a_feature_level: assert property (feature_conn_en == tim_ff[TIM_FEAT])
        else $error("feature connector enable wrong");
    a_overlay_gate: assert property (up_ff && $past(ce) |-> overlay_window_flag ==
        ($past(tim_ff[TIM_OVERLAY]) & $past(overlay_region))) else $error("overlay flag wrong");
    a_sync_pass: assert property (up_ff && $past(ce) && !$past(tim_ff[TIM_POWER_EN]) |->
        hsync_out == $past(hsync_in)) else $error("hsync not passed through");
    a_precharge_rise: assert property (ce && precharge_start |=> cas_precharge)
        else $error("precharge pulse missing");
    a_precharge_short: assert property (ce && precharge_start && !tim_ff[TIM_PRECHG] ##1
        (ce && !precharge_start) |=> !cas_precharge) else $error("short precharge too long");
    a_precharge_long: assert property (ce && precharge_start && tim_ff[TIM_PRECHG] ##1
        (ce && !precharge_start) |=> cas_precharge ##1 (!cas_precharge || $past(precharge_start)))
        else $error("long precharge length wrong");
    a_cycle_trim: assert property (host_cycle_len ==
        STD_HOST_CYCLE - {1'b0, tim_ff[1:0]}) else $error("host cycle length wrong");
    c_long_pre: cover property (ce && precharge_start && tim_ff[TIM_PRECHG]);
    c_asym_bus: cover property (geom_ff[GEOM_ASYM] && mux_addr_in[9]);
    c_power_on: cover property (tim_ff[TIM_POWER_EN] && hsync_out);
endmodule : ecrb_core_assertions
bind ecrb_core ecrb_core_assertions u_chk (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .mux_addr_in(mux_addr_in), .dram_mux_address_bus(dram_mux_address_bus),
    .mem_path_32(mem_path_32), .fast_mclk(fast_mclk), .precharge_start(precharge_start),
    .cas_precharge(cas_precharge), .host_cycle_len(host_cycle_len),
    .feature_conn_en(feature_conn_en), .overlay_region(overlay_region),
    .overlay_window_flag(overlay_window_flag), .hsync_in(hsync_in), .hsync_out(hsync_out));
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ecrb_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [20:0] disp_addr_in = 21'h1F_FFFF;
    logic [9:0] mux_addr_in = 10'h3FF;
    logic precharge_start = 1'b0;
    logic overlay_region = 1'b0;
    logic hsync_in = 1'b0, vsync_in = 1'b0, ddc_pin = 1'b0;
    logic [1:0] strap_lines_high = 2'b01;
    logic dram_type_strap = 1'b1;
    logic enable_port_strap = 1'b0;
    logic linear_en = 1'b0;
    logic [15:0] win_addr = 16'h0123;
    logic win_wr = 1'b0;
    logic [7:0] io_rdata;
    logic [20:0] disp_addr_out, win_mem_addr;
    logic [9:0] dram_mux_address_bus;
    logic [2:0] host_cycle_len;
    logic mem_path_32, fast_mclk, cas_precharge, feature_conn_en, overlay_window_flag;
    logic hsync_out, vsync_out, vsync_ddc_timing;
    logic [7:0] d;
    int error_cnt = 0, n_compared = 0, cycles = 0, cnt;
    ecrb_core uut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .disp_addr_in(disp_addr_in),
        .disp_addr_out(disp_addr_out), .mux_addr_in(mux_addr_in),
        .dram_mux_address_bus(dram_mux_address_bus), .mem_path_32(mem_path_32),
        .fast_mclk(fast_mclk), .precharge_start(precharge_start), .cas_precharge(cas_precharge),
        .host_cycle_len(host_cycle_len), .feature_conn_en(feature_conn_en),
        .overlay_region(overlay_region), .overlay_window_flag(overlay_window_flag),
        .hsync_in(hsync_in), .vsync_in(vsync_in), .hsync_out(hsync_out), .vsync_out(vsync_out),
        .vsync_ddc_timing(vsync_ddc_timing), .ddc_pin(ddc_pin),
        .strap_lines_high(strap_lines_high), .dram_type_strap(dram_type_strap),
        .enable_port_strap(enable_port_strap), .linear_en(linear_en), .win_addr(win_addr),
        .win_wr(win_wr), .win_mem_addr(win_mem_addr));
    // 10 MHz core clock
    always #50 core_clk = ~core_clk;
    // Cut a hang short; the run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // Strobes drop for a cycle between accesses
    task automatic io_write(input logic [15:0] a, input logic [7:0] v);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = v;
        io_wr = 1'b1;
        @(negedge core_clk);
        io_wr = 1'b0;
    endtask : io_write
    task automatic io_read(input logic [15:0] a, output logic [7:0] v);
        @(negedge core_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge core_clk);
        io_rd = 1'b0;
        v = io_rdata;
    endtask : io_read
    function automatic logic [15:0] port_of(input logic [7:0] i);
        return (i >= 8'h20 && i != 8'h2E) ? GC_INDEX_PORT : SEQ_INDEX_PORT;
    endfunction : port_of
    task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
        io_write(port_of(i), i);
        io_write(port_of(i) + 16'h0001, v);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] i, output logic [7:0] v);
        io_write(port_of(i), i);
        io_read(port_of(i) + 16'h0001, v);
    endtask : reg_rd
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    localparam logic [7:0] IDX [6] = '{8'h15, 8'h17, 8'h18, 8'h20, 8'h21, 8'h22};
    localparam logic [7:0] MSK [6] = '{8'h37, 8'h6F, 8'hF4, 8'h7F, 8'h7F, 8'hFF};
    localparam logic [7:0] GV [5] = '{8'h00, 8'h10, 8'h14, 8'h02, 8'h21};
    localparam logic [20:0] DM [5] = '{21'h03_FFFF, 21'h0F_FFFF, 21'h1F_FFFF, 21'h03_FFFF,
        21'h03_FFFF};
    localparam logic [7:0] EXV [8] = '{8'h00, 8'h00, 8'h09, 8'h09, 8'h08, 8'h01, 8'h02, 8'h00};
    localparam logic [7:0] WRV [8] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    localparam logic [20:0] SEGX [8] = '{21'h05_0123, 21'h05_0123, 21'h03_0123, 21'h05_0123,
        21'h05_0123, 21'h05_0123, 21'h19_4123, 21'h00_0123};
    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        check(host_cycle_len, 3'h6);
        for (int i = 0; i < 6; i++) begin
            reg_rd(IDX[i], d);
            check(d, 8'h00);
            reg_wr(IDX[i], 8'hFF);
            reg_rd(IDX[i], d);
            check(d, MSK[i]);
            reg_wr(IDX[i], 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            reg_wr(i == 0 ? 8'h1F : 8'h2E, 8'hFF);
            reg_rd(i == 0 ? 8'h1F : 8'h2E, d);
            check(d, i == 0 ? 8'h40 : 8'h80);
        end
        reg_rd(8'h19, d);
        check(d, 8'h00);
        io_read(SEQ_INDEX_PORT, d);
        check(d, 8'h19);
        $display("register access test done");
        for (int i = 0; i < 5; i++) begin
            reg_wr(IDX_MEM_GEOMETRY, GV[i]);
            @(negedge core_clk);
            check(disp_addr_out, DM[i]);
            check(dram_mux_address_bus, {GV[i][1], 9'h1FF});
            check({mem_path_32, fast_mclk}, {GV[i][5], GV[i][0]});
        end
        $display("geometry test done");
        overlay_region = 1'b1;
        for (int k = 0; k < 4; k++) begin
            reg_wr(IDX_MEM_TIMING, 8'h60 | 8'(k));
            @(negedge core_clk);
            check(host_cycle_len, 3'h6 - 3'(k));
            check({feature_conn_en, overlay_window_flag}, 2'b11);
        end
        for (int k = 0; k < 2; k++) begin
            reg_wr(IDX_MEM_TIMING, 8'(k * 4));
            @(negedge core_clk);
            check({feature_conn_en, overlay_window_flag}, 2'b00);
            precharge_start = 1'b1;
            @(negedge core_clk);
            precharge_start = 1'b0;
            cnt = 0;
            repeat (4) begin
                cnt += (cas_precharge === 1'b1) ? 1 : 0;
                @(negedge core_clk);
            end
            check(cnt, k + 1);
        end
        $display("timing test done");
        reg_wr(IDX_MEM_TIMING, 8'h08);
        for (int m = 0; m < 4; m++) begin
            reg_wr(IDX_MON_POWER, 8'hC0 | 8'(m << 4));
            @(negedge core_clk);
            check({hsync_out, vsync_out}, {m[0], m[1]});
        end
        hsync_in = 1'b1;
        vsync_in = 1'b1;
        reg_wr(IDX_MON_POWER, 8'h30);
        @(negedge core_clk);
        check({hsync_out, vsync_out}, 2'b00);
        reg_wr(IDX_MEM_TIMING, 8'h00);
        reg_wr(IDX_MON_POWER, 8'h34);
        ddc_pin = 1'b1;
        @(negedge core_clk);
        check({hsync_out, vsync_out, vsync_ddc_timing}, 3'b111);
        reg_rd(IDX_MON_POWER, d);
        check(d, 8'h37);
        $display("power test done");
        reg_wr(IDX_READ_SEG, 8'hE5);
        reg_wr(IDX_WRITE_SEG, 8'h03);
        for (int i = 0; i < 8; i++) begin
            reg_wr(IDX_EXT_MODE, EXV[i]);
            win_wr = WRV[i][0];
            linear_en = (i == 7);
            @(negedge core_clk);
            @(negedge core_clk);
            check(win_mem_addr, SEGX[i]);
        end
        // With the enable low the block must drop a whole register write
        ce = 1'b0;
        reg_wr(IDX_MEM_TIMING, 8'h40);
        ce = 1'b1;
        check(feature_conn_en, 1'b0);
        $display("segment test done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
